// ### dv/pbw_reader.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// far-side instrument: reads the shared bcd lines, reports each new presentation
module pbw_reader (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [23:0] bcd_data_o,
  input  wire logic        bcd_data_oe,
  input  wire logic [2:0]  type_sel,
  output logic             got,
  output logic [2:0]       got_type,
  output logic [23:0]      got_data
);
  logic [23:0] last_q;
  logic [23:0] wire_lvl;
  logic [26:0] seen_q;
  logic        oe_q;

  // released lines float: show the inverse of the last level so a stale value never passes
  assign wire_lvl = (bcd_data_oe === 1'b1) ? bcd_data_o : ~last_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_q   <= 24'h000000;
      seen_q   <= 27'h0000000;
      oe_q     <= 1'b0;
      got      <= 1'b0;
      got_type <= 3'h0;
      got_data <= 24'h000000;
    end else begin
      last_q <= wire_lvl;
      oe_q   <= bcd_data_oe;
      got    <= 1'b0;
      // a fresh type/value pair, or lines driven again after a release
      if (bcd_data_oe && type_sel != 3'h0 &&
          (!oe_q || {type_sel, wire_lvl} != seen_q)) begin
        got      <= 1'b1;
        got_type <= type_sel;
        got_data <= wire_lvl;
        seen_q   <= {type_sel, wire_lvl};
      end
    end
  end
endmodule // pbw_reader
`default_nettype wire

// ### dv/test_parallel_bcd_weight_output.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbw_regs.svh"

module test_parallel_bcd_weight_output;
  localparam int unsigned STROBE = 8;
  localparam int unsigned GAP    = 4;

  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [23:0] gross_val = 24'h0, net_val = 24'h0, tare_val = 24'h0;
  logic        new_value = 1'b0;
  logic [1:0]  display_mode = 2'h0;
  logic        print_button = 1'b0, serial_print_cmd = 1'b0, remote_print_n = 1'b1;
  logic        output_release_n = 1'b1;
  logic        jmp_a = 1'b0, jmp_b = 1'b0;
  logic [23:0] bcd_data_o;
  logic        bcd_data_oe;
  logic [2:0]  type_sel;
  logic        print_strobe;
  logic        got;
  logic [2:0]  got_type;
  logic [23:0] got_data;
  logic [26:0] q[$];
  time         gaps[$];
  time         t_prev = 0;
  logic [31:0] rs = 32'h3efc;
  logic [23:0] gv, nv, tv;
  int          n_mismatch = 0;
  int          checks_done = 0;

  always #25 clk = ~clk;

  pbw_top #(.STROBE_CYC(STROBE), .GAP_CYC(GAP)) pbw_top_i (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .gross_val(gross_val), .net_val(net_val), .tare_val(tare_val),
    .new_value(new_value), .display_mode(display_mode), .print_button(print_button),
    .serial_print_cmd(serial_print_cmd), .remote_print_n(remote_print_n),
    .output_release_n(output_release_n), .strobe_polarity_jumper_a(jmp_a),
    .strobe_polarity_jumper_b(jmp_b), .bcd_data_o(bcd_data_o),
    .bcd_data_oe(bcd_data_oe), .type_sel(type_sel), .print_strobe(print_strobe));

  pbw_reader pbw_reader_i (
    .clk(clk), .resetn(resetn), .bcd_data_o(bcd_data_o), .bcd_data_oe(bcd_data_oe),
    .type_sel(type_sel), .got(got), .got_type(got_type), .got_data(got_data));

  // ============================================================
  // helpers
  task automatic cmp(input logic [31:0] act, input logic [31:0] exp);
    checks_done++;
    if (act !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic give_verdict();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic [23:0] rnd_bcd();
    logic [23:0] r;
    for (int i = 0; i < 6; i++) begin
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      r[i*4+:4] = 4'(rs % 10);
    end
    return r;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp(reg_rdata, exp);
  endtask

  task automatic new_vals();
    @(posedge clk);
    gv = rnd_bcd();
    nv = rnd_bcd();
    tv = rnd_bcd();
    gross_val <= gv;
    net_val <= nv;
    tare_val <= tv;
  endtask

  // 0 new value, 1 button, 2 serial command, 3 remote contact to ground
  task automatic trig(input int k);
    @(posedge clk);
    case (k)
      0: new_value <= 1'b1;
      1: print_button <= 1'b1;
      2: serial_print_cmd <= 1'b1;
      default: remote_print_n <= 1'b0;
    endcase
    @(posedge clk);
    new_value <= 1'b0;
    print_button <= 1'b0;
    serial_print_cmd <= 1'b0;
    remote_print_n <= 1'b1;
  endtask

  task automatic measure(input logic inv);
    int w;
    int n;
    w = 0;
    n = 0;
    while (w < 20 && print_strobe === inv) begin
      @(posedge clk);
      #1 w++;
    end
    while (n < 40 && print_strobe === ~inv) begin
      @(posedge clk);
      #1 n++;
    end
    cmp(32'(n), STROBE);
  endtask

  task automatic settle();
    for (int i = 0; i < 200 && q.size() != 0; i++) @(posedge clk);
    cmp(32'(q.size()), 32'h0);
    repeat (STROBE + GAP + 4) @(posedge clk);
  endtask

  // ============================================================
  // result watcher: oldest note against each presentation
  always @(posedge clk) begin
    if (got === 1'b1) begin
      cmp({5'h0, got_type, got_data}, {5'h0, (q.size() != 0) ? q.pop_front() : 27'hx});
      gaps.push_back($time - t_prev);
      t_prev = $time;
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  // ============================================================
  // scenarios
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(`PBW_CTRL_OFS, 32'h00000001);
    rd(4'h8, 32'h00000000);
    rd(`PBW_STAT_OFS, 32'h00000040);
    new_vals();
    q.push_back({3'h1, gv});
    trig(0);
    measure(1'b0);
    settle();
    wr(`PBW_CTRL_OFS, 32'h00000007);
    rd(`PBW_CTRL_OFS, 32'h00000007);
    new_vals();
    q.push_back({3'h1, gv});
    q.push_back({3'h2, nv});
    q.push_back({3'h4, tv});
    trig(0);
    settle();
    cmp(32'(gaps[gaps.size()-1]), GAP * 50);
    cmp(32'(gaps[gaps.size()-2]), GAP * 50);
    new_vals();
    repeat (2) for (int i = 0; i < 1; i++) begin
      q.push_back({3'h1, gv});
      q.push_back({3'h2, nv});
      q.push_back({3'h4, tv});
    end
    trig(0);
    repeat (3) @(posedge clk);
    trig(2);
    settle();
    // print-gated: a fresh weight alone must not reach the port
    wr(`PBW_CTRL_OFS, 32'h00000011);
    new_vals();
    trig(0);
    repeat (12) @(posedge clk);
    for (int k = 1; k < 4; k++) begin
      new_vals();
      q.push_back({3'h1, gv});
      trig(k);
      settle();
    end
    wr(`PBW_CTRL_OFS, 32'h00000008);
    for (int m = 1; m < 4; m++) begin
      @(posedge clk);
      display_mode <= 2'(m % 3);
      q.push_back({3'(1 << (m % 3)), (m == 1) ? nv : (m == 2) ? tv : gv});
      settle();
    end
    // a display showing no weight type selects nothing: no presentation may follow
    @(posedge clk);
    display_mode <= 2'h3;
    repeat (STROBE + GAP + 4) @(posedge clk);
    cmp(32'(q.size()), 32'h0);
    wr(`PBW_CTRL_OFS, 32'h00000001);
    @(posedge clk);
    output_release_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 cmp({31'h0, bcd_data_oe}, 32'h0);
    new_vals();
    trig(0);
    measure(1'b0);
    settle();
    q.push_back({3'h1, gv});
    output_release_n <= 1'b1;
    settle();
    jmp_b <= 1'b1;
    repeat (2) @(posedge clk);
    #1 cmp({31'h0, print_strobe}, 32'h1);
    new_vals();
    q.push_back({3'h1, gv});
    trig(1);
    measure(1'b1);
    settle();
    give_verdict();
  end
endmodule // test_parallel_bcd_weight_output
`default_nettype wire

// ### hw/pbw_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbw_regs.svh"

module pbw_timer #(
  parameter int unsigned CYC = 1
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic start,
  output logic      active,
  output logic      done
);

  // ============================================================
  // down counter; a start while running retriggers the full width
  logic [`PBW_CNT_W-1:0] cnt_q;
  logic [`PBW_CNT_W-1:0] cnt_d;
  logic                  act_q;
  logic                  act_d;

  always_comb begin
    cnt_d = cnt_q;
    act_d = act_q;
    if (start) begin
      cnt_d = `PBW_CNT_W'(CYC - 1); // see R14
      act_d = 1'b1;
    end else if (act_q && cnt_q == '0) begin
      act_d = 1'b0;
    end else if (act_q) begin
      cnt_d = cnt_q - `PBW_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
      act_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      act_q <= act_d;
    end
  end

  assign active = act_q;
  // done must not look at start: start is built from done one level up
  assign done   = act_q && cnt_q == '0;

  chk_timer_load: assert property (@(posedge clk) disable iff (!resetn) // see R14
    start |=> act_q && cnt_q == `PBW_CNT_W'(CYC - 1))
    else $error("timer did not load full count");

  chk_timer_end: assert property (@(posedge clk) disable iff (!resetn) // see R14
    (act_q && cnt_q == '0 && !start) |=> !act_q)
    else $error("timer ran past its count");

endmodule // pbw_timer
`default_nettype wire

// ### hw/pbw_top.sv
// Contract
// R01 - control flags select gross, net, tare, follow-display and print-gated output
// R02 - print-gated: port data changes only on a print trigger
// R03 - not print-gated: port data updates on each new weight value
// R04 - print trigger from front button, serial command or grounded remote input
// R05 - output-release low puts all data lines in high impedance
// R06 - output-release high again drives the latched data, no new trigger
// R07 - print strobe idles low and pulses high for 25 ms per event
// R08 - polarity jumper inverts the strobe: idles high, pulses low
// R09 - weight-type select outputs show which value is presented
// R10 - all three selected: presented in turn, 10 ms apart
// R11 - follow-display: port carries the displayed type, follows mode changes
// R12 - strobes continue while data lines are released
// R13 - trigger during a sequence is held until the sequence ends
// R14 - strobe and spacing timed by cycle counters scaled to the clock
`timescale 1ns/1ps
`default_nettype none
`include "pbw_regs.svh"

module pbw_top
  import pbw_pkg::*;
#(
  parameter int unsigned STROBE_CYC = `PBW_STROBE_CYC,
  parameter int unsigned GAP_CYC    = `PBW_GAP_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic [23:0] gross_val,
  input  wire logic [23:0] net_val,
  input  wire logic [23:0] tare_val,
  input  wire logic        new_value,
  input  wire logic [1:0]  display_mode,
  input  wire logic        print_button,
  input  wire logic        serial_print_cmd,
  input  wire logic        remote_print_n,
  input  wire logic        output_release_n,
  input  wire logic        strobe_polarity_jumper_a,
  input  wire logic        strobe_polarity_jumper_b,
  output logic      [23:0] bcd_data_o,
  output logic             bcd_data_oe,
  output logic      [2:0]  type_sel,
  output logic             print_strobe
);

  // ============================================================
  // helpers
  function automatic logic [2:0] mode_mask(input logic [1:0] m);
    unique case (m)
      `PBW_DISP_GROSS: mode_mask = 3'h1;
      `PBW_DISP_NET:   mode_mask = 3'h2;
      `PBW_DISP_TARE:  mode_mask = 3'h4;
      default:         mode_mask = 3'h0;
    endcase
  endfunction

  function automatic logic [2:0] first_bit(input logic [2:0] m);
    first_bit = m & (~m + 3'h1);
  endfunction

  function automatic logic [23:0] pick_val(input logic [2:0] t);
    pick_val = t[`PBW_SEL_TARE] ? tare_val
             : t[`PBW_SEL_NET]  ? net_val : gross_val;
  endfunction

  // ============================================================
  // register port
  logic [`PBW_CTRL_W-1:0] ctrl_q;
  logic [`PBW_CTRL_W-1:0] ctrl_d;
  logic [31:0]            rdata_q;
  logic [31:0]            rdata_d;
  logic [31:0]            status;

  pbw_state_t  state_q;
  pbw_state_t  state_d;
  logic        pending;
  logic        print_evt;
  logic        str_active;
  logic        gap_done;
  logic [23:0] data_q;
  logic [23:0] data_d;
  logic [2:0]  type_q;
  logic [2:0]  type_d;
  logic [2:0]  remain_q;
  logic [2:0]  remain_d;
  logic        oe_q;
  logic        oe_d;
  logic        strobe_q;
  logic        strobe_d;
  logic [1:0]  disp_q;
  logic [1:0]  disp_d;

  always_comb begin
    status = '0;
    status[`PBW_ST_BUSY]                = state_q == PBW_SPACE;
    status[`PBW_ST_PEND]                = pending;
    status[`PBW_ST_TYPE+2:`PBW_ST_TYPE] = type_q;
    status[`PBW_ST_STROBE]              = str_active;
    status[`PBW_ST_OE]                  = oe_q;
  end

  always_comb begin
    ctrl_d  = ctrl_q;
    rdata_d = '0;
    if (reg_wr && reg_addr == `PBW_CTRL_OFS) begin
      ctrl_d = reg_wdata[`PBW_CTRL_W-1:0]; // see R01
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `PBW_CTRL_OFS: rdata_d = {{(32-`PBW_CTRL_W){1'b0}}, ctrl_q};
        `PBW_STAT_OFS: rdata_d = status;
        default:       rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q  <= `PBW_CTRL_RST;
      rdata_q <= '0;
    end else begin
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ============================================================
  // triggers
  logic gated;
  logic follow;
  logic disp_change;
  logic take;

  assign gated       = ctrl_q[`PBW_SEL_PRINT];
  assign follow      = ctrl_q[`PBW_SEL_DISP];
  // a display mode change counts as fresh data when following the display
  assign disp_change = follow && (display_mode != disp_q); // see R11
  assign take        = (state_q == PBW_IDLE) && pending; // see R13

  pbw_trig u_trig (
    .clk              (clk),
    .resetn           (resetn),
    .print_button     (print_button),
    .serial_print_cmd (serial_print_cmd),
    .remote_print_n   (remote_print_n),
    .gated            (gated),
    .new_value        (new_value),
    .disp_change      (disp_change),
    .take             (take),
    .pending          (pending),
    .print_evt        (print_evt)
  );

  // ============================================================
  // sequencer
  logic [2:0] start_mask;
  logic [2:0] cur;
  logic       step;
  logic       seq_start;

  always_comb begin
    start_mask = follow ? mode_mask(display_mode) // see R11
                        : ctrl_q[`PBW_SEL_TARE:`PBW_SEL_GROSS]; // see R01
    seq_start  = take && start_mask != 3'h0;
    state_d    = state_q;
    data_d     = data_q;
    type_d     = type_q;
    remain_d   = remain_q;
    cur        = 3'h0;
    step       = 1'b0;
    disp_d     = display_mode;
    unique case (state_q)
      PBW_IDLE: begin
        if (seq_start) begin
          cur  = first_bit(start_mask);
          step = 1'b1;
          remain_d = start_mask & ~cur;
        end
      end
      PBW_SPACE: begin
        if (gap_done) begin // see R10
          cur  = first_bit(remain_q);
          step = 1'b1;
          remain_d = remain_q & ~cur;
        end
      end
      default: begin
        state_d = PBW_IDLE;
      end
    endcase
    if (step) begin
      // data only moves here, so gating holds the last value in between
      data_d  = pick_val(cur); // see R02 see R03
      type_d  = cur; // see R09
      state_d = (remain_d != 3'h0) ? PBW_SPACE : PBW_IDLE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= PBW_IDLE;
      data_q   <= '0;
      type_q   <= 3'h0;
      remain_q <= 3'h0;
      disp_q   <= 2'h0;
    end else begin
      state_q  <= state_d;
      data_q   <= data_d;
      type_q   <= type_d;
      remain_q <= remain_d;
      disp_q   <= disp_d;
    end
  end

  pbw_timer #(.CYC(GAP_CYC)) u_gap (
    .clk    (clk),
    .resetn (resetn),
    .start  (step && remain_d != 3'h0), // see R10 see R14
    .active (),
    .done   (gap_done)
  );

  // ============================================================
  // strobe and pin drive
  logic invert;

  // one strobe per sequence; rapid continuous updates retrigger and stretch it
  pbw_timer #(.CYC(STROBE_CYC)) u_strobe (
    .clk    (clk),
    .resetn (resetn),
    .start  (seq_start), // see R07 see R14
    .active (str_active),
    .done   ()
  );

  assign invert = strobe_polarity_jumper_b && !strobe_polarity_jumper_a;

  always_comb begin
    strobe_d = str_active ^ invert; // see R07 see R08 see R12
    oe_d     = output_release_n; // see R05 see R06
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strobe_q <= 1'b0;
      oe_q     <= 1'b0;
    end else begin
      strobe_q <= strobe_d;
      oe_q     <= oe_d;
    end
  end

  assign bcd_data_o   = data_q;
  assign bcd_data_oe  = oe_q;
  assign type_sel     = type_q;
  assign print_strobe = strobe_q;

  // ============================================================
  // checks
  // cycles since the last value step, kept only for the spacing check
  logic [`PBW_CNT_W-1:0] since_q;
  logic [`PBW_CNT_W-1:0] since_d;

  always_comb begin
    since_d = since_q;
    if (step) begin
      since_d = '0;
    end else if (since_q != '1) begin
      since_d = since_q + `PBW_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      since_q <= '0;
    end else begin
      since_q <= since_d;
    end
  end

  sequence s_release_back;
    !output_release_n ##1 output_release_n;
  endsequence

  chk_oe_release: assert property (@(posedge clk) disable iff (!resetn) // see R05
    !output_release_n |=> !bcd_data_oe)
    else $error("data driven while released");

  chk_oe_return: assert property (@(posedge clk) disable iff (!resetn) // see R06
    s_release_back |=> bcd_data_oe && $stable(bcd_data_o))
    else $error("latched data not restored");

  chk_data_hold: assert property (@(posedge clk) disable iff (!resetn) // see R02
    !step |=> $stable(bcd_data_o))
    else $error("data changed without a step");

  chk_gated_ignore: assert property (@(posedge clk) disable iff (!resetn) // see R02
    (gated && !print_evt && !pending) |=> !pending)
    else $error("gated port armed without print");

  chk_cont_update: assert property (@(posedge clk) disable iff (!resetn) // see R03
    (!gated && new_value) |=> pending || state_q == PBW_SPACE || $past(take))
    else $error("new value not taken");

  chk_strobe_pol: assert property (@(posedge clk) disable iff (!resetn) // see R08
    ##1 print_strobe == ($past(str_active) ^ $past(invert)))
    else $error("strobe polarity wrong");

  chk_strobe_fire: assert property (@(posedge clk) disable iff (!resetn) // see R12
    (seq_start && !invert) ##1 !invert |=> print_strobe)
    else $error("strobe missing");

  chk_type_onehot: assert property (@(posedge clk) disable iff (!resetn) // see R09
    $onehot0(type_sel))
    else $error("type select not one-hot");

  chk_gap_spacing: assert property (@(posedge clk) disable iff (!resetn) // see R10
    (state_q == PBW_SPACE && step) |-> since_q == `PBW_CNT_W'(GAP_CYC - 1))
    else $error("value stepped before spacing");

  chk_follow_type: assert property (@(posedge clk) disable iff (!resetn) // see R11
    (follow && seq_start) |=> type_sel == mode_mask($past(display_mode)))
    else $error("type does not follow display");

endmodule // pbw_top
`default_nettype wire

// ### hw/pbw_trig.sv
`timescale 1ns/1ps
`default_nettype none

module pbw_trig (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic print_button,
  input  wire logic serial_print_cmd,
  input  wire logic remote_print_n,
  input  wire logic gated,
  input  wire logic new_value,
  input  wire logic disp_change,
  input  wire logic take,
  output logic      pending,
  output logic      print_evt
);

  // ============================================================
  // trigger collection and hold
  logic btn_q;
  logic btn_d;
  logic rem_q;
  logic rem_d;
  logic pend_q;
  logic pend_d;
  logic evt;

  always_comb begin
    btn_d = print_button;
    rem_d = remote_print_n;
    // button press edge, serial command pulse, remote contact closing to ground
    print_evt = (print_button && !btn_q) || serial_print_cmd
                || (!remote_print_n && rem_q); // see R04
    evt = print_evt || (!gated && (new_value || disp_change)); // see R02 see R03
    // a new event in the take cycle re-arms, so nothing is lost
    pend_d = evt || (pend_q && !take); // see R13
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      btn_q  <= 1'b0;
      rem_q  <= 1'b1;
      pend_q <= 1'b0;
    end else begin
      btn_q  <= btn_d;
      rem_q  <= rem_d;
      pend_q <= pend_d;
    end
  end

  assign pending = pend_q;

  chk_pend_kept: assert property (@(posedge clk) disable iff (!resetn) // see R13
    (pend_q && !take) |=> pend_q)
    else $error("held trigger was dropped");

endmodule // pbw_trig
`default_nettype wire

// ### pkg/pbw_pkg.sv
`default_nettype none
package pbw_pkg;

  // ============================================================
  // sequencer states
  typedef enum logic [1:0] {
    PBW_IDLE  = 2'b01,
    PBW_SPACE = 2'b10
  } pbw_state_t;

endpackage
`default_nettype wire

// ### pkg/pbw_regs.svh
`ifndef PBW_REGS_SVH
`define PBW_REGS_SVH

// ============================================================
// register offsets (byte addresses on the plain register port)
`define PBW_CTRL_OFS   4'h0
`define PBW_STAT_OFS   4'h4

// ============================================================
// control register fields (value_select_flags)
`define PBW_SEL_GROSS  0
`define PBW_SEL_NET    1
`define PBW_SEL_TARE   2
`define PBW_SEL_DISP   3
`define PBW_SEL_PRINT  4
`define PBW_CTRL_W     5
`define PBW_CTRL_RST   5'h01

// ============================================================
// status register fields
`define PBW_ST_BUSY    0
`define PBW_ST_PEND    1
`define PBW_ST_TYPE    2
`define PBW_ST_STROBE  5
`define PBW_ST_OE      6

// ============================================================
// display mode codes
`define PBW_DISP_GROSS 2'h0
`define PBW_DISP_NET   2'h1
`define PBW_DISP_TARE  2'h2

// ============================================================
// timing
`define PBW_CLK_KHZ    20000
`define PBW_STROBE_MS  25
`define PBW_GAP_MS     10
`define PBW_STROBE_CYC (`PBW_STROBE_MS * `PBW_CLK_KHZ)
`define PBW_GAP_CYC    (`PBW_GAP_MS * `PBW_CLK_KHZ)
`define PBW_CNT_W      20

`endif
